//--- core/sbp_consts.svh
// Constants of the system bus port: register offsets, field positions,
// reset values and transfer counts. Definitions only.
`ifndef SBP_CONSTS_SVH
`define SBP_CONSTS_SVH

`define SBP_OFS_MODE      8'h00
`define SBP_OFS_STATUS    8'h04
`define SBP_OFS_MASK      8'h08

`define SBP_BIT_EARLY     0
`define SBP_BIT_BUSERR    25
`define SBP_BIT_DONE      0

`define SBP_EARLY_RST     1'b0
`define SBP_MASK_RST      1'b0
`define SBP_DIR_RST       1'b1

`define SBP_WORD_W        32
`define SBP_LEN_W         5
`define SBP_FIFO_DEPTH    4
`define SBP_LEN_ONE       5'h01
`define SBP_LEN_TWO       5'h02
`define SBP_ADDR_STEP     32'h0000_0004

`endif

//--- core/sbp_pkg.sv
// Types shared by the system bus port modules.
// Assumes sbp_consts.svh sits on the include path.
`include "sbp_consts.svh"

package sbp_pkg;

	typedef logic [`SBP_WORD_W-1:0] sbp_word_t;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'h0,
		ST_REQ     = 3'h1,
		ST_ADDR    = 3'h3,
		ST_DATA    = 3'h2,
		ST_BACKOFF = 3'h6,
		ST_HALT    = 3'h4
	} sbp_dma_e;

	typedef struct packed {
		sbp_dma_e              st;
		logic                  dir_rd;
		sbp_word_t             addr;
		logic [`SBP_LEN_W-1:0] rem;
		logic                  req_n;
		sbp_word_t             ad_out;
		logic                  ad_oe;
		logic                  loaded;
		sbp_word_t             rd_data;
		logic                  rd_valid;
		logic                  done;
		logic                  early;
		logic                  err_flag;
		logic                  done_flag;
		logic                  mask_err;
		logic                  mask_done;
		logic [7:0]            slv_addr;
		logic                  slv_rd;
		logic                  slv_done;
		logic                  asel_prev;
	} sbp_port_s;

endpackage

//--- core/sbp_sync.sv
// Three-stage pin synchroniser with an agreement filter.
// Pins are asynchronous to core_clk; a change is taken once stages two and three agree.
`timescale 1ns/10ps

module sbp_sync #(
	parameter int                 WIDTH   = 1,
	parameter logic [WIDTH-1:0]   RST_VAL = '0
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0]      level,
	output logic [WIDTH-1:0]      early
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] filt;
	} sbp_sync_s;

	localparam sbp_sync_s SYNC_RST = '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, filt: RST_VAL};

	sbp_sync_s q;
	sbp_sync_s n;
	logic [WIDTH-1:0] agree;

	assign agree = q.s2 ~^ q.s3;

	always_comb begin
		n      = q;
		n.s1   = pin;
		n.s2   = q.s1;
		n.s3   = q.s2;
		n.filt = (agree & q.s3) | (~agree & q.filt);
	end

	// The early view is the value the filter takes at the next edge.
	assign early = n.filt;
	assign level = q.filt;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			q <= SYNC_RST;
		else
			q <= n;
	end

endmodule

//--- core/sbp_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
// DEPTH must be a power of two so that the pointers wrap by themselves.
`timescale 1ns/10ps

module sbp_fifo #(
	parameter int                 WIDTH = 32,
	parameter int                 DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);

	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wp;
		logic [PW-1:0]               rp;
		logic [CW-1:0]               cnt;
	} sbp_fifo_s;

	sbp_fifo_s q;
	sbp_fifo_s n;
	logic      push;
	logic      pop;

	assign in_ready  = q.cnt != CW'(DEPTH);
	assign out_valid = q.cnt != '0;
	assign out_data  = q.mem[q.rp];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb begin
		n = q;
		if (push) begin
			n.mem[q.wp] = in_data;
			n.wp        = q.wp + 1'b1;
		end
		if (pop)
			n.rp = q.rp + 1'b1;
		if (push && !pop)
			n.cnt = q.cnt + 1'b1;
		else if (pop && !push)
			n.cnt = q.cnt - 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			q <= '0;
		else
			q <= n;
	end

endmodule

//--- core/sbp_port.sv
// System bus port: DMA master engine and directly addressed slave registers.
// Bus pins are asynchronous and pass the pin synchroniser; the user side is on core_clk.
`timescale 1ns/10ps
`include "sbp_consts.svh"

// Summary of operation
// [RL1] Direction output high for DMA reads, low for writes, high after reset.
// [RL2] Request/burst-frame output driven low while a DMA operation runs.
// [RL3] Request released at the edge where one word remains to transfer.
// [RL4] Low grant lets the device start the requested transfer.
// [RL5] Arbiter grants no earlier than one clock after the request rises; the bus model grants three clocks after it falls, seven when slow.
// [RL6] Arbiter returns grant high before the next request is made.
// [RL7] Target drives ready low when read data is valid or write accepted.
// [RL8] Early mode samples ready and abort one clock sooner.
// [RL9] Abort drops the cycle, releases request briefly, then resumes at that word.
// [RL10] Ready is ignored while abort is low.
// [RL11] Bus error halts all bus work, sets status bit 25 if unmasked.
// [RL12] Host drives slave direction high to read, low to write.
// [RL13] Host asserts slave select no earlier than address select.
// [RL14] Slave select stays inactive at least two clocks between accesses.
// [RL15] Address select low captures the bus address at the next edge.
// [RL16] Reset clears state and registers and releases every three-state output.
// [RL17] Reset acts asynchronously, without a clock edge.
// [RL18] Reset is held low for at least one clock.
// [RL19] Host waits at least 20 clocks after reset before access.
// [RL20] Interrupt pin pulled low while any unmasked status bit is set.
// [RL21] Normal mode advances a word only on ready low with abort high.
module sbp_port
	import sbp_pkg::*;
(
	input  wire logic                  core_clk,
	input  wire logic                  rst_n,
	output logic                       dma_direction_n,
	output logic                       dma_request_frame_n,
	input  wire logic                  bus_grant_n,
	input  wire logic                  target_ready_n,
	input  wire logic                  transfer_abort_n,
	input  wire logic                  bus_error_n,
	input  wire logic                  slave_direction_n,
	input  wire logic                  slave_select_n,
	input  wire logic                  slave_addr_select_n,
	input  wire logic [31:0]           muxed_addr_data_bus_in,
	output logic [31:0]                muxed_addr_data_bus_out,
	output logic                       muxed_addr_data_bus_oe,
	output logic                       irq_out_n,
	output logic                       irq_out_oe,
	input  wire logic                  cmd_valid,
	output logic                       cmd_ready,
	input  wire logic                  cmd_read,
	input  wire logic [31:0]           cmd_addr,
	input  wire logic [`SBP_LEN_W-1:0] cmd_len,
	input  wire logic                  wr_valid,
	output logic                       wr_ready,
	input  wire logic [31:0]           wr_data,
	output logic                       rd_valid,
	output logic [31:0]                rd_data,
	output logic                       dma_busy,
	output logic                       dma_done,
	output logic                       bus_halted
);

	localparam int GNT  = 6;
	localparam int RDY  = 5;
	localparam int ABT  = 4;
	localparam int ERR  = 3;
	localparam int SDIR = 2;
	localparam int SEL  = 1;
	localparam int ASEL = 0;

	localparam sbp_port_s PORT_RST = '{
		st:        ST_IDLE,
		dir_rd:    `SBP_DIR_RST,
		req_n:     1'b1,
		early:     `SBP_EARLY_RST,
		mask_err:  `SBP_MASK_RST,
		mask_done: `SBP_MASK_RST,
		asel_prev: 1'b1,
		default:   '0
	};

	sbp_port_s q;
	sbp_port_s n;
	logic [6:0] ctl_pin;
	logic [6:0] ctl_s;
	logic [6:0] ctl_e;
	sbp_word_t  ad_s;
	sbp_word_t  ad_e;
	sbp_word_t  ad_v;
	sbp_word_t  fifo_data;
	logic       fifo_valid;
	logic       fifo_pop;
	logic       rdy_ok;
	logic       abt;
	logic       grant_ok;
	logic       halt_req;
	logic       advance;
	logic       asel_fall;
	logic       sel_rd;
	logic       slv_wr;
	logic       w1c;
	logic       dma_free;

	function automatic sbp_word_t reg_rd(input logic [7:0] a, input sbp_port_s s);
		sbp_word_t v;
		v = '0;
		case (a)
			`SBP_OFS_MODE: v[`SBP_BIT_EARLY] = s.early;
			`SBP_OFS_STATUS: begin
				v[`SBP_BIT_BUSERR] = s.err_flag;
				v[`SBP_BIT_DONE]   = s.done_flag;
			end
			`SBP_OFS_MASK: begin
				v[`SBP_BIT_BUSERR] = s.mask_err;
				v[`SBP_BIT_DONE]   = s.mask_done;
			end
			default: v = '0;
		endcase
		return v;
	endfunction

	assign ctl_pin = {bus_grant_n, target_ready_n, transfer_abort_n, bus_error_n,
		slave_direction_n, slave_select_n, slave_addr_select_n};

	sbp_sync #(.WIDTH(7), .RST_VAL(7'h7f)) u_ctl_sync (
		.clk   (core_clk),
		.rst_n (rst_n),
		.pin   (ctl_pin),
		.level (ctl_s),
		.early (ctl_e)
	);

	sbp_sync #(.WIDTH(`SBP_WORD_W), .RST_VAL(32'h0000_0000)) u_ad_sync (
		.clk   (core_clk),
		.rst_n (rst_n),
		.pin   (muxed_addr_data_bus_in),
		.level (ad_s),
		.early (ad_e)
	);

	// Write words wait here; an empty FIFO stalls the burst.
	sbp_fifo #(.WIDTH(`SBP_WORD_W), .DEPTH(`SBP_FIFO_DEPTH)) u_wr_fifo (
		.clk       (core_clk),
		.rst_n     (rst_n),
		.in_valid  (wr_valid),
		.in_ready  (wr_ready),
		.in_data   (wr_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_data)
	);

	// [RL8] early sample select
	assign ad_v     = q.early ? ad_e : ad_s;
	assign rdy_ok   = q.early ? ~ctl_e[RDY] : ~ctl_s[RDY];
	assign abt      = q.early ? ~ctl_e[ABT] : ~ctl_s[ABT];
	assign grant_ok = ~ctl_s[GNT];
	assign halt_req = ~ctl_s[ERR];
	// [RL10] ready masked by abort
	// [RL21] word advance condition
	assign advance  = (q.st == ST_DATA) & rdy_ok & ~abt & (q.dir_rd | q.loaded);
	assign fifo_pop = advance & ~q.dir_rd;
	// [RL15] address select edge
	assign asel_fall = ~ctl_s[ASEL] & q.asel_prev;
	assign sel_rd    = ~ctl_s[SEL] & ctl_s[ASEL] & q.slv_rd;
	assign slv_wr    = ~ctl_s[SEL] & ctl_s[ASEL] & ~q.slv_rd & ~q.slv_done;
	assign w1c       = slv_wr & (q.slv_addr == `SBP_OFS_STATUS);
	assign dma_free  = (q.st == ST_IDLE) | (q.st == ST_HALT);
	assign cmd_ready = (q.st == ST_IDLE) & ~halt_req & ctl_s[SEL];

	always_comb begin
		n           = q;
		n.rd_valid  = 1'b0;
		n.done      = 1'b0;
		n.asel_prev = ctl_s[ASEL];

		// [RL15] slave address capture
		if (asel_fall) begin
			n.slv_addr = ad_v[7:0];
			n.slv_rd   = ctl_s[SDIR];
		end
		if (ctl_s[SEL])
			n.slv_done = 1'b0;
		else if (slv_wr)
			n.slv_done = 1'b1;
		if (slv_wr && q.slv_addr == `SBP_OFS_MODE)
			n.early = ad_v[`SBP_BIT_EARLY];
		if (slv_wr && q.slv_addr == `SBP_OFS_MASK) begin
			n.mask_err  = ad_v[`SBP_BIT_BUSERR];
			n.mask_done = ad_v[`SBP_BIT_DONE];
		end

		unique case (q.st)
			ST_IDLE: begin
				// [RL1] direction rests high
				n.dir_rd = 1'b1;
				if (cmd_valid && cmd_ready) begin
					n.st     = ST_REQ;
					n.dir_rd = cmd_read;
					n.addr   = cmd_addr;
					n.rem    = cmd_len;
					// [RL2] request asserted
					n.req_n  = 1'b0;
				end
			end
			ST_REQ: begin
				// [RL4] grant starts transfer
				if (grant_ok) begin
					n.st     = ST_ADDR;
					// [RL3] single word release
					n.req_n  = (q.rem == `SBP_LEN_ONE);
					n.ad_out = q.addr;
					n.ad_oe  = 1'b1;
				end
			end
			ST_ADDR: begin
				n.st     = ST_DATA;
				n.ad_oe  = ~q.dir_rd;
				n.loaded = 1'b0;
			end
			ST_DATA: begin
				if (abt) begin
					// [RL9] abort and back off
					n.st     = ST_BACKOFF;
					n.req_n  = 1'b1;
					n.ad_oe  = 1'b0;
					n.loaded = 1'b0;
				end else if (!q.dir_rd && !q.loaded) begin
					if (fifo_valid) begin
						n.ad_out = fifo_data;
						n.loaded = 1'b1;
					end
				end else if (advance) begin
					n.addr   = q.addr + `SBP_ADDR_STEP;
					n.rem    = q.rem - 1'b1;
					n.loaded = 1'b0;
					if (q.dir_rd) begin
						n.rd_data  = ad_v;
						n.rd_valid = 1'b1;
					end
					// [RL3] release before last word
					if (q.rem == `SBP_LEN_TWO)
						n.req_n = 1'b1;
					if (q.rem == `SBP_LEN_ONE) begin
						n.st    = ST_IDLE;
						n.done  = 1'b1;
						n.ad_oe = 1'b0;
						n.req_n = 1'b1;
					end
				end
			end
			ST_BACKOFF: begin
				// [RL6] wait for grant release
				// [RL9] resume at aborted word
				if (!grant_ok) begin
					n.st    = ST_REQ;
					n.req_n = 1'b0;
				end
			end
			ST_HALT: begin
				if (!halt_req && !q.err_flag)
					n.st = ST_IDLE;
			end
			default: begin
				n.st    = ST_HALT;
				n.req_n = 1'b1;
				n.ad_oe = 1'b0;
			end
		endcase

		// [RL11] bus error halts
		if (halt_req) begin
			n.st     = ST_HALT;
			n.req_n  = 1'b1;
			n.ad_oe  = 1'b0;
			n.loaded = 1'b0;
		end

		// Slave reads may use the bus only while the DMA engine leaves it free.
		if (sel_rd && dma_free && !halt_req) begin
			n.ad_oe  = 1'b1;
			n.ad_out = reg_rd(q.slv_addr, q);
		end else if (dma_free) begin
			n.ad_oe = 1'b0;
		end

		// [RL11] error flag, set wins
		n.err_flag  = (q.err_flag & ~(w1c & ad_v[`SBP_BIT_BUSERR]))
			| (halt_req & ~q.mask_err);
		n.done_flag = (q.done_flag & ~(w1c & ad_v[`SBP_BIT_DONE]))
			| (n.done & ~q.mask_done);
	end

	// [RL16] reset loads PORT_RST into all state
	// [RL17] asynchronous reset
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			q <= PORT_RST;
		else
			q <= n;
	end

	// [RL1] direction from register
	assign dma_direction_n         = q.dir_rd;
	assign dma_request_frame_n     = q.req_n;
	assign muxed_addr_data_bus_out = q.ad_out;
	assign muxed_addr_data_bus_oe  = q.ad_oe;
	// [RL20] open-drain interrupt
	assign irq_out_n               = 1'b0;
	assign irq_out_oe              = q.err_flag | q.done_flag;
	assign rd_valid                = q.rd_valid;
	assign rd_data                 = q.rd_data;
	assign dma_done                = q.done;
	assign dma_busy                = ~dma_free;
	assign bus_halted              = q.st == ST_HALT;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	property p_dir_follow;
		(cmd_valid && cmd_ready) |=> (dma_direction_n == $past(cmd_read));
	endproperty
	a_dir_follow: assert property (p_dir_follow) // [RL1]
		else $error("direction does not follow the accepted command");

	property p_req_low;
		(q.st == ST_REQ) |-> !dma_request_frame_n;
	endproperty
	a_req_low: assert property (p_req_low) // [RL2]
		else $error("request not low while requesting");

	property p_req_last;
		(advance && q.rem == `SBP_LEN_TWO) |=> dma_request_frame_n;
	endproperty
	a_req_last: assert property (p_req_last) // [RL3]
		else $error("request not released with one word left");

	property p_grant;
		(q.st == ST_REQ && grant_ok && !halt_req)
			|=> (q.st == ST_ADDR) ##1 (q.st == ST_DATA || q.st == ST_HALT);
	endproperty
	a_grant: assert property (p_grant) // [RL4]
		else $error("grant did not start the transfer");

	property p_early;
		(q.early && q.st == ST_DATA && !ctl_e[ABT] && !halt_req) |=> (q.st == ST_BACKOFF);
	endproperty
	a_early: assert property (p_early) // [RL8]
		else $error("early abort not taken");

	property p_abort;
		(q.st == ST_DATA && abt && !halt_req)
			|=> dma_request_frame_n && (q.addr == $past(q.addr)) && (q.st == ST_BACKOFF);
	endproperty
	a_abort: assert property (p_abort) // [RL9]
		else $error("abort did not back off at the same word");

	property p_abort_masks;
		(q.st == ST_DATA && abt) |=> (q.rem == $past(q.rem)) && !rd_valid;
	endproperty
	a_abort_masks: assert property (p_abort_masks) // [RL10]
		else $error("word advanced while abort low");

	property p_bus_error;
		(halt_req && !q.mask_err)
			|=> q.err_flag && bus_halted && !muxed_addr_data_bus_oe && dma_request_frame_n;
	endproperty
	a_bus_error: assert property (p_bus_error) // [RL11]
		else $error("bus error did not halt and flag");

	property p_slave_addr;
		asel_fall |=> (q.slv_addr == $past(ad_v[7:0]));
	endproperty
	a_slave_addr: assert property (p_slave_addr) // [RL15]
		else $error("slave address not captured");

	property p_irq;
		(dma_done && !q.mask_done) |-> irq_out_oe ##1 (irq_out_oe || $past(w1c));
	endproperty
	a_irq: assert property (p_irq) // [RL20]
		else $error("interrupt not driven for unmasked status");

	property p_hold;
		(q.st == ST_DATA && !q.early && !(!ctl_s[RDY] && ctl_s[ABT]))
			|=> (q.rem == $past(q.rem));
	endproperty
	a_hold: assert property (p_hold) // [RL21]
		else $error("word advanced without ready");

endmodule

//--- dv/sbp_bus_model.sv
// Arbiter and target on the far side of the system bus port.
// Assumes the bench resolves the address/data wire and feeds it back in.
`timescale 1ns/10ps

module sbp_bus_model (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        req_n,
	input  wire logic        dir_n,
	input  wire logic        ad_oe,
	input  wire logic [31:0] ad_bus,
	input  wire logic        slow,
	output logic             gnt_n,
	output logic             rdy_n,
	output logic             rd_en,
	output logic [31:0]      rd_word
);
	logic [2:0] wait_r;
	logic [4:0] quiet_r;
	logic [1:0] phase_r;
	logic       active_r;

	// Read data stands on the wire while the target is active with direction high; it stays active until the request has been released for 24 clocks.
	assign rd_en = active_r & dir_n;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			gnt_n    <= 1'b1;
			rdy_n    <= 1'b1;
			wait_r   <= 3'h0;
			quiet_r  <= 5'h00;
			phase_r  <= 2'h0;
			active_r <= 1'b0;
			rd_word  <= 32'h0000_0000;
		end else begin
			phase_r <= phase_r + 2'h1;
			if (!req_n)
				quiet_r <= 5'h00;
			else if (quiet_r != 5'h1f)
				quiet_r <= quiet_r + 5'h01;
			if (!req_n && gnt_n) begin
				wait_r <= wait_r + 3'h1;
				if (wait_r == (slow ? 3'h6 : 3'h2))
					gnt_n <= 1'b0;
			end else begin
				wait_r <= 3'h0;
			end
			if (req_n && !gnt_n)
				gnt_n <= 1'b1;
			if (!gnt_n && ad_oe && !active_r) begin
				active_r <= 1'b1;
				rd_word  <= ~ad_bus;
			end else if (quiet_r == 5'h18) begin
				active_r <= 1'b0;
			end
			rdy_n <= !(active_r && !(slow && phase_r[1]));
		end
	end
endmodule

//--- dv/test_sbp_port.sv
// Self-checking bench for the system bus port: DMA and slave access.
// Assumes sbp_consts.svh on the include path and a pull-up on the interrupt wire.
`timescale 1ns/10ps
`include "sbp_consts.svh"

module test_sbp_port;
	logic        core_clk, rst_n, bus_error_n, transfer_abort_n, slow;
	logic        slave_direction_n, slave_select_n, slave_addr_select_n;
	logic        cmd_valid, cmd_ready, cmd_read, wr_valid, wr_ready, rd_valid;
	logic        dma_direction_n, dma_request_frame_n, bus_grant_n, target_ready_n;
	logic        ad_oe, irq_out_n, irq_out_oe, dma_busy, dma_done, bus_halted;
	logic        tb_en, m_en, exp_dir, done_seen, req_at_done, prev_req;
	logic [31:0] ad_in, ad_out, tb_ad, m_word, cmd_addr, wr_data, rd_data, exp_rd;
	logic [31:0] last_ad = '0;
	logic [31:0] cap[$];
	logic [4:0]  cmd_len;
	int          mismatches, checks, rd_cnt, rd_hi, req_falls, dir_bad;
	wire         irq_wire = irq_out_oe ? irq_out_n : 1'b1;

	assign ad_in = ad_oe ? ad_out : tb_en ? tb_ad : m_en ? m_word : ~last_ad;
	always @(posedge core_clk) last_ad <= ad_in;

	sbp_port u_dut (.core_clk(core_clk), .rst_n(rst_n), .dma_direction_n(dma_direction_n),
		.dma_request_frame_n(dma_request_frame_n), .bus_grant_n(bus_grant_n),
		.target_ready_n(target_ready_n), .transfer_abort_n(transfer_abort_n),
		.bus_error_n(bus_error_n), .slave_direction_n(slave_direction_n),
		.slave_select_n(slave_select_n), .slave_addr_select_n(slave_addr_select_n),
		.muxed_addr_data_bus_in(ad_in), .muxed_addr_data_bus_out(ad_out),
		.muxed_addr_data_bus_oe(ad_oe), .irq_out_n(irq_out_n), .irq_out_oe(irq_out_oe),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
		.cmd_addr(cmd_addr), .cmd_len(cmd_len), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data), .dma_busy(dma_busy),
		.dma_done(dma_done), .bus_halted(bus_halted));

	sbp_bus_model u_model (.core_clk(core_clk), .rst_n(rst_n), .req_n(dma_request_frame_n),
		.dir_n(dma_direction_n), .ad_oe(ad_oe), .ad_bus(ad_in), .slow(slow),
		.gnt_n(bus_grant_n), .rdy_n(target_ready_n), .rd_en(m_en), .rd_word(m_word));

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// Watches the wire and the user side of every DMA transfer.
	always @(negedge core_clk) begin
		if (rd_valid === 1'b1) begin
			rd_cnt++;
			if (dma_request_frame_n === 1'b1)
				rd_hi++;
			check("rd_data", rd_data, exp_rd);
		end
		if (dma_busy === 1'b1 && ad_oe === 1'b1 && (cap.size() == 0 || cap[$] !== ad_out))
			cap.push_back(ad_out);
		if (dma_busy === 1'b1 && dma_direction_n !== exp_dir)
			dir_bad++;
		if (prev_req === 1'b1 && dma_request_frame_n === 1'b0)
			req_falls++;
		prev_req = dma_request_frame_n;
		if (dma_done === 1'b1) begin
			done_seen   = 1'b1;
			req_at_done = dma_request_frame_n;
		end
	end

	// address phase, then select, then a gap
	task automatic slv(input logic rd, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(negedge core_clk);
		slave_direction_n   = rd;
		slave_addr_select_n = 1'b0;
		tb_en               = 1'b1;
		tb_ad               = {24'h00_0000, a};
		tick(4);
		slave_addr_select_n = 1'b1;
		slave_select_n      = 1'b0;
		tb_ad               = d;
		tb_en               = !rd;
		q                   = 'x;
		repeat (12) begin
			@(negedge core_clk);
			if (rd && ad_oe === 1'b1)
				q = ad_out;
		end
		slave_select_n = 1'b1;
		tb_en          = 1'b0;
		tick(4);
	endtask

	task automatic dma(input logic rd, input logic [31:0] a, input logic [4:0] n);
		int t;
		@(negedge core_clk);
		cmd_read  = rd;
		cmd_addr  = a;
		cmd_len   = n;
		cmd_valid = 1'b1;
		exp_dir   = rd;
		exp_rd    = ~a;
		cap.delete();
		{rd_cnt, rd_hi, req_falls, dir_bad, done_seen} = '0;
		for (t = 0; t < 50 && cmd_ready !== 1'b1; t++)
			@(negedge core_clk);
		@(negedge core_clk);
		cmd_valid = 1'b0;
		for (t = 0; t < 400 && !done_seen; t++)
			@(negedge core_clk);
		check("dma_done", done_seen, 1'b1);
		check("busy_done", dma_busy, 1'b0);
		check("dir_held", dir_bad, 0);
		check("req_released", req_at_done, 1'b1);
		tick(30);
	endtask

	task automatic push4(input logic [31:0] b);
		for (int i = 0; i < 4; i++) begin
			@(negedge core_clk);
			wr_valid = 1'b1;
			wr_data  = b + 32'(i);
		end
		@(negedge core_clk);
		wr_valid = 1'b0;
		check("fifo_full", wr_ready, 1'b0);
	endtask

	initial begin
		logic [31:0] q;
		{rst_n, cmd_valid, cmd_read, wr_valid, tb_en, slow} = '0;
		{bus_error_n, transfer_abort_n, slave_select_n, slave_addr_select_n} = '1;
		{slave_direction_n, prev_req, exp_dir} = '1;
		{cmd_addr, wr_data, tb_ad, exp_rd} = '0;
		cmd_len = 5'h01;
		tick(2);
		check("dir_rst", dma_direction_n, `SBP_DIR_RST);
		check("req_rst", dma_request_frame_n, 1'b1);
		check("ad_oe_rst", ad_oe, 1'b0);
		check("irq_rst", irq_wire, 1'b1);
		tick(4);
		rst_n = 1'b1;
		tick(20);
		slv(1'b1, `SBP_OFS_MODE, 0, q);
		check("mode_rst", q, 0);
		slv(1'b1, `SBP_OFS_MASK, 0, q);
		check("mask_rst", q, 0);
		slv(1'b1, 8'h3c, 0, q);
		check("unmapped", q, 0);
		$display("test registers done");
		slow = 1'b1;
		push4(32'h5a5a_0010);
		dma(1'b0, 32'h0000_1000, 5'h04);
		check("wr_words", cap.size(), 5);
		for (int i = 0; i < 5; i++)
			check("wr_word", cap[i], i == 0 ? 32'h0000_1000 : 32'h5a5a_000f + 32'(i));
		check("irq_done", irq_wire, 1'b0);
		slv(1'b1, `SBP_OFS_STATUS, 0, q);
		check("status_done", q, 32'h1 << `SBP_BIT_DONE);
		slv(1'b0, `SBP_OFS_STATUS, 32'h1 << `SBP_BIT_DONE, q);
		slv(1'b0, `SBP_OFS_MASK, 32'h0000_0001, q);
		check("irq_done_clr", irq_wire, 1'b1);
		$display("test dma write done");
		slow = 1'b0;
		dma(1'b1, 32'h0000_2000, 5'h02);
		check("rd_count", rd_cnt, 2);
		check("req_last", rd_hi, 2);
		$display("test dma read done");
		slv(1'b0, `SBP_OFS_MODE, 32'h0000_0001, q);
		dma(1'b1, 32'h0000_3000, 5'h03);
		check("rd_count_early", rd_cnt, 3);
		check("req_last_early", rd_hi, 2);
		slv(1'b1, `SBP_OFS_MODE, 0, q);
		check("mode", q, 1);
		$display("test early mode done");
		slow = 1'b1;
		push4(32'hc3c3_0000);
		fork
			dma(1'b0, 32'h0000_4000, 5'h04);
			begin
				for (int t = 0; t < 200 && cap.size() < 2; t++)
					@(negedge core_clk);
				transfer_abort_n = 1'b0;
				tick(4);
				transfer_abort_n = 1'b1;
			end
		join
		check("req_again", req_falls > 1, 1'b1);
		check("resumed_last", cap[$], 32'hc3c3_0003);
		$display("test abort done");
		bus_error_n = 1'b0;
		tick(8);
		check("halted", bus_halted, 1'b1);
		check("cmd_refused", cmd_ready, 1'b0);
		check("irq_err", irq_wire, 1'b0);
		bus_error_n = 1'b1;
		tick(8);
		check("halt_kept", bus_halted, 1'b1);
		slv(1'b1, `SBP_OFS_STATUS, 0, q);
		check("status", q, 32'h1 << `SBP_BIT_BUSERR);
		slv(1'b0, `SBP_OFS_STATUS, 32'h1 << `SBP_BIT_BUSERR, q);
		check("halt_left", bus_halted, 1'b0);
		check("irq_clear", irq_wire, 1'b1);
		slv(1'b0, `SBP_OFS_MASK, 32'h0200_0001, q);
		bus_error_n = 1'b0;
		tick(8);
		check("halt_masked", bus_halted, 1'b1);
		check("irq_masked", irq_wire, 1'b1);
		rst_n = 1'b0;
		#1 check("async_rst", bus_halted, 1'b0);
		$display("test bus error done");
		results();
	end

	initial begin
		#400000;
		mismatches++;
		results();
	end
endmodule
